/* File: acrd_defines.vh */
// Constants for the converter clock and data-rate divider block
//
// Contract
// - Sample clock is the analog clock divided by a fixed four.
// - One modulator sample per sample clock period, output refreshed once per output data-rate period.
// - Output data rate is sample rate divided by the selected oversampling ratio.
// - Each new result is announced by a low pulse on data_ready_n.
// - Select codes 000..111 map to ratios 32 through 4096, doubling each step.
// - Oversampling ratio resets to 256, code 011.
// - Prescale 11,10,01,00 gives analog clock /8,/4,/2,/1, sample clock /32,/16,/8,/4.
// - Each channel has its own 24-bit offset trim word.
// - Each channel has its own 24-bit gain trim word.
// - Prescale select resets to 00, divide by one.
// - Data-ready low lasts one sample clock period, recurring at output rate.
`ifndef ACRD_DEFINES_VH
`define ACRD_DEFINES_VH

`define ACRD_ADDR_W 4
`define ACRD_ADDR_CONFIG 4'h0
`define ACRD_ADDR_STATUS 4'h1
`define ACRD_ADDR_MASK 4'h2
`define ACRD_ADDR_OFFSET0 4'h4
`define ACRD_ADDR_GAIN0 4'h5
`define ACRD_ADDR_OFFSET1 4'h6
`define ACRD_ADDR_GAIN1 4'h7
`define ACRD_ADDR_COUNT 4'h8

`define ACRD_PRE_LSB 0
`define ACRD_PRE_MSB 1
`define ACRD_OSR_LSB 4
`define ACRD_OSR_MSB 6

`define ACRD_PRE_RESET 2'h0
`define ACRD_OSR_RESET 3'h3
`define ACRD_TRIM_RESET 24'h000000
`define ACRD_TRIM_W 24

`define ACRD_SAMPLE_DIV 2'h3
`define ACRD_OSR_BASE 12'h01F
`define ACRD_CNT_W 12

`define ACRD_ST_READY 0
`define ACRD_ST_RESTART 1
`define ACRD_ST_W 2

`endif

/* File: acrd_prescaler.v */
// Master clock prescaler producing analog clock enable pulses
`timescale 1ns/100ps
`default_nettype none
`include "acrd_defines.vh"
module acrd_prescaler (
  input wire clk_i, // Master clock
  input wire reset_n_i, // Async reset, active low
  input wire restart_i, // Restart the divider
  input wire [1:0] pre_sel_i, // Prescale select
  output wire tick_o // One-cycle analog clock enable
);
  reg [2:0] cnt_q;
  wire [2:0] last_w;
  // Select 00..11 divides by 1,2,4,8
  assign last_w = (3'h1 << pre_sel_i) - 3'h1;
  assign tick_o = (cnt_q == last_w) && !restart_i;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 3'h0;
    end else if (restart_i || cnt_q == last_w) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: acrd_rate_counter.v */
// Enable-gated modulo counter used for the sample and data-rate stages
`timescale 1ns/100ps
`default_nettype none
`include "acrd_defines.vh"
module acrd_rate_counter (
  input wire clk_i, // Master clock
  input wire reset_n_i, // Async reset, active low
  input wire restart_i, // Restart the count
  input wire en_i, // Count enable
  input wire [11:0] last_i, // Terminal count, modulus minus one
  output wire wrap_o // One-cycle pulse at terminal count
);
  reg [11:0] cnt_q;
  assign wrap_o = en_i && (cnt_q == last_i) && !restart_i;
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 12'h000;
    end else if (restart_i) begin
      cnt_q <= 12'h000;
    end else if (en_i) begin
      if (cnt_q == last_i) begin
        cnt_q <= 12'h000;
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: acrd_clock_divider.v */
// Converter clock chain: prescaler, divide-by-four, decimation rate and trim words
`timescale 1ns/100ps
`default_nettype none
`include "acrd_defines.vh"
module acrd_clock_divider (
  input wire clk_i, // Master clock, 10 MHz
  input wire reset_n_i, // Async reset, active low
  input wire [3:0] addr_i, // Register address
  input wire [31:0] wdata_i, // Write data
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  output reg [31:0] rdata_o, // Read data, cycle after read strobe
  output wire analog_clock_o, // Analog clock enable pulse
  output wire sample_clock_o, // Sample clock enable pulse
  output wire output_rate_tick_o, // Output data-rate pulse
  output reg data_ready_n_o, // Data-ready, active low
  output reg [23:0] offset_trim_word0_o, // Channel 0 offset trim
  output reg [23:0] offset_trim_word1_o, // Channel 1 offset trim
  output reg [23:0] gain_trim_word0_o, // Channel 0 gain trim
  output reg [23:0] gain_trim_word1_o, // Channel 1 gain trim
  output wire irq_o // Interrupt, active high level
);
  reg [1:0] pre_q;
  reg [2:0] osr_q;
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg restart_q;
  reg [1:0] status_d;
  wire cfg_wr_w;
  wire [11:0] osr_last_w;
  wire [11:0] smp_last_w;
  wire [11:0] osr_cnt_w;

  assign cfg_wr_w = wr_i && (addr_i == `ACRD_ADDR_CONFIG);

  // Restart is held one cycle after a config write so the dividers start clean
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= cfg_wr_w;
    end
  end

  acrd_prescaler u_pre (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(restart_q),
    .pre_sel_i(pre_q),
    .tick_o(analog_clock_o)
  );

  assign smp_last_w = {10'h000, `ACRD_SAMPLE_DIV};
  acrd_rate_counter u_smp (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(restart_q),
    .en_i(analog_clock_o),
    .last_i(smp_last_w),
    .wrap_o(sample_clock_o)
  );

  // Ratio is 32 shifted by the select code, minus one for the terminal count
  assign osr_cnt_w = `ACRD_OSR_BASE;
  assign osr_last_w = ((osr_cnt_w + 12'h001) << osr_q) - 12'h001;
  acrd_rate_counter u_osr (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .restart_i(restart_q),
    .en_i(sample_clock_o),
    .last_i(osr_last_w),
    .wrap_o(output_rate_tick_o)
  );

  // Low from one rate tick to the next sample clock: one sample period wide
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_ready_n_o <= 1'b1;
    end else if (restart_q) begin
      data_ready_n_o <= 1'b1;
    end else if (output_rate_tick_o) begin
      data_ready_n_o <= 1'b0;
    end else if (sample_clock_o) begin
      data_ready_n_o <= 1'b1;
    end
  end

  // Status: ready event and restart event; write one to clear, set wins
  always @* begin
    status_d = status_q;
    if (wr_i && addr_i == `ACRD_ADDR_STATUS) begin
      status_d = status_q & ~wdata_i[`ACRD_ST_W-1:0];
    end
    if (output_rate_tick_o) begin
      status_d[`ACRD_ST_READY] = 1'b1;
    end
    if (restart_q) begin
      status_d[`ACRD_ST_RESTART] = 1'b1;
    end
  end
  assign irq_o = |(status_q & mask_q);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= `ACRD_PRE_RESET;
      osr_q <= `ACRD_OSR_RESET;
      status_q <= 2'h0;
      mask_q <= 2'h0;
      offset_trim_word0_o <= `ACRD_TRIM_RESET;
      offset_trim_word1_o <= `ACRD_TRIM_RESET;
      gain_trim_word0_o <= `ACRD_TRIM_RESET;
      gain_trim_word1_o <= `ACRD_TRIM_RESET;
    end else begin
      status_q <= status_d;
      if (wr_i) begin
        case (addr_i)
          `ACRD_ADDR_CONFIG: begin
            pre_q <= wdata_i[`ACRD_PRE_MSB:`ACRD_PRE_LSB];
            osr_q <= wdata_i[`ACRD_OSR_MSB:`ACRD_OSR_LSB];
          end
          `ACRD_ADDR_MASK: mask_q <= wdata_i[`ACRD_ST_W-1:0];
          `ACRD_ADDR_OFFSET0: offset_trim_word0_o <= wdata_i[`ACRD_TRIM_W-1:0];
          `ACRD_ADDR_OFFSET1: offset_trim_word1_o <= wdata_i[`ACRD_TRIM_W-1:0];
          `ACRD_ADDR_GAIN0: gain_trim_word0_o <= wdata_i[`ACRD_TRIM_W-1:0];
          `ACRD_ADDR_GAIN1: gain_trim_word1_o <= wdata_i[`ACRD_TRIM_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Read data valid only in the cycle after the strobe; zero otherwise
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `ACRD_ADDR_CONFIG: rdata_o <= {25'h0, osr_q, 2'h0, pre_q};
        `ACRD_ADDR_STATUS: rdata_o <= {30'h0, status_q};
        `ACRD_ADDR_MASK: rdata_o <= {30'h0, mask_q};
        `ACRD_ADDR_OFFSET0: rdata_o <= {8'h00, offset_trim_word0_o};
        `ACRD_ADDR_GAIN0: rdata_o <= {8'h00, gain_trim_word0_o};
        `ACRD_ADDR_OFFSET1: rdata_o <= {8'h00, offset_trim_word1_o};
        `ACRD_ADDR_GAIN1: rdata_o <= {8'h00, gain_trim_word1_o};
        `ACRD_ADDR_COUNT: rdata_o <= {20'h0, osr_last_w};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* File: acrd_clock_divider_assertions.sv */
// Port checker for the converter clock divider
`timescale 1ns/100ps
`default_nettype none
module acrd_clock_divider_assertions (
  input wire clk_i, // Clock
  input wire reset_n_i, // Reset
  input wire [3:0] addr_i, // Address
  input wire [31:0] wdata_i, // Write data
  input wire wr_i, // Write strobe
  input wire analog_clock_o, // Analog pulse
  input wire sample_clock_o, // Sample pulse
  input wire output_rate_tick_o, // Rate tick
  input wire data_ready_n_o, // Data ready
  input wire [23:0] offset_trim_word0_o, // Offset 0
  input wire [23:0] gain_trim_word0_o // Gain 0
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sample_on_analog_a: assert property (sample_clock_o |-> analog_clock_o)
    else $error("sample pulse off analog pulse");
  tick_on_sample_a: assert property (output_rate_tick_o |-> sample_clock_o)
    else $error("rate tick off sample pulse");
  ready_after_tick_a: assert property (output_rate_tick_o |=> !data_ready_n_o)
    else $error("no data ready after tick");
  ready_cause_a: assert property ($fell(data_ready_n_o) |-> $past(output_rate_tick_o))
    else $error("data ready without tick");
  ready_min_width_a: assert property ($fell(data_ready_n_o) |-> !data_ready_n_o [*4])
    else $error("data ready pulse too short");
  ready_end_a: assert property (!data_ready_n_o && sample_clock_o |=> data_ready_n_o)
    else $error("data ready pulse too long");
  restart_quiet_a: assert property (wr_i && addr_i == 4'h0 |=> !output_rate_tick_o [*8])
    else $error("tick soon after restart");
  offset_load_a: assert property (wr_i && addr_i == 4'h4 |=>
    {8'h00, offset_trim_word0_o} == ($past(wdata_i) & 32'h00FFFFFF))
    else $error("offset trim not loaded");
  gain_load_a: assert property (wr_i && addr_i == 4'h5 |=>
    {8'h00, gain_trim_word0_o} == ($past(wdata_i) & 32'h00FFFFFF))
    else $error("gain trim not loaded");
endmodule
bind acrd_clock_divider acrd_clock_divider_assertions u_acrd_clock_divider_assertions (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .analog_clock_o(analog_clock_o), .sample_clock_o(sample_clock_o),
  .output_rate_tick_o(output_rate_tick_o), .data_ready_n_o(data_ready_n_o),
  .offset_trim_word0_o(offset_trim_word0_o), .gain_trim_word0_o(gain_trim_word0_o));
`default_nettype wire

/* File: acrd_host_model.sv */
// Host interrupt input model that times data-ready pulses
`timescale 1ns/100ps
`default_nettype none
module acrd_host_model (
  input wire logic clk_i, // Clock
  input wire logic data_ready_n_i, // Data ready
  output logic [31:0] period_o, // Clocks between falls
  output logic [31:0] width_o // Clocks low
);
  logic [31:0] since = 32'h0;
  logic last = 1'b1;
  always @(posedge clk_i) begin
    since <= since + 32'h1;
    last <= data_ready_n_i;
    if (last && !data_ready_n_i) begin
      period_o <= since;
      since <= 32'h1;
    end
    if (!last && data_ready_n_i)
      width_o <= since;
  end
endmodule
`default_nettype wire

/* File: tb_acrd_clock_divider.sv */
// Testbench for the converter clock divider
`timescale 1ns/100ps
`default_nettype none
module tb_acrd_clock_divider;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [31:0] rdata_o, period, width;
  wire ana, smp, tick, drdy_n, irq;
  wire [23:0] ofs0, ofs1, gn0, gn1;
  int fails = 0;
  int tests_run = 0;
  always #50 clk_i = ~clk_i;
  acrd_clock_divider u_acrd_clock_divider (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .analog_clock_o(ana), .sample_clock_o(smp), .output_rate_tick_o(tick),
    .data_ready_n_o(drdy_n), .offset_trim_word0_o(ofs0), .offset_trim_word1_o(ofs1),
    .gain_trim_word0_o(gn0), .gain_trim_word1_o(gn1), .irq_o(irq));
  acrd_host_model u_acrd_host_model (.clk_i(clk_i), .data_ready_n_i(drdy_n),
    .period_o(period), .width_o(width));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Returns half a cycle after a pulse ends: host counts are settled by then,
  // and a config write that follows can never cut a pulse short
  task automatic await_ready(input int n);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (k < 5000 && drdy_n !== 1'b0) begin
        @(posedge clk_i);
        k++;
      end
      while (k < 5000 && drdy_n !== 1'b1) begin
        @(posedge clk_i);
        k++;
      end
      if (k >= 5000) begin
        fails++;
        $display("unexpected at %0t: no data ready pulse", $time);
      end
    end
    @(negedge clk_i);
  endtask
  task automatic conclude;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin : seq
    logic [31:0] d;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, d); check(d, 32'h30);
    rd(4'h8, d); check(d, 32'hFF);
    rd(4'h3, d); check(d, 32'h0);
    $display("reset values done");
    for (int i = 4; i < 8; i++) begin
      wr(i[3:0], 32'hA5C30000 + i);
      rd(i[3:0], d); check(d, 32'h00C30000 + i);
    end
    check({8'h00, ofs1}, 32'h00C30006);
    check({8'h00, gn1}, 32'h00C30007);
    $display("trim words done");
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, {25'h0, c[2:0], 4'h0});
      rd(4'h8, d); check(d, (32'h20 << c) - 32'h1);
    end
    $display("ratio codes done");
    for (int p = 0; p < 5; p++) begin
      wr(4'h0, p < 4 ? p : 32'h13);
      await_ready(2);
      check(period, p < 4 ? 32'h80 << p : 32'h800);
      check(width, p < 4 ? 32'h4 << p : 32'h20);
    end
    $display("rates done");
    wr(4'h1, 32'h3);
    wr(4'h0, 32'h13);
    rd(4'h1, d); check(d, 32'h2);
    wr(4'h1, 32'h2);
    wr(4'h2, 32'h1);
    rd(4'h1, d); check(d, 32'h0);
    check({31'h0, irq}, 32'h0);
    await_ready(1);
    check({31'h0, irq}, 32'h1);
    wr(4'h1, 32'h1);
    rd(4'h1, d); check(d, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(4'h2, 32'h0);
    await_ready(1);
    rd(4'h1, d); check(d, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("interrupt done");
    conclude();
  end
endmodule
`default_nettype wire
